/* File: design/mcl_top.sv */
// Contract
// - fault status and retry log flag decimal unit errors in bit 53, immediate ROM in 54, operand bus upper bits in 55.
// - bits 56 to 59 flag translation buffer parity errors and bit 60 a multiple hit.
// - bit 61 stays zero, bit 62 flags a maintenance access control error, bit 63 any control store parity error.
// - the translation log holds file 0 in bit 56 and two bits each for files 1, 2 and 3 above it.
// - all maintenance registers answer only on link channel 17 octal.
// - the designated peripheral processor can read every register and write registers to set up conditions.
// - memory writes from selected ports outside the lower and upper bounds are rejected.
// - the bounds register is loaded only through the link.
// - memory words are 64 bits with only the low 60 carrying data in legacy mode.
// - the translation buffer has four units 0 to 3 that can each be enabled or disabled.
// - a translation held in the buffer completes without a table fetch from memory.
// - opcode 27 is a no-operation and the program counter is readable over the link.
// - fault status and retry logs hold central processor errors; fault status also takes the multiple hit and link access errors.
module mcl_top (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic [4:0]  mch_chan,
    input  wire logic        mch_rd,
    input  wire logic        mch_wr,
    input  wire logic [7:0]  mch_addr,
    input  wire logic [63:0] mch_wdata,
    output logic      [63:0] mch_rdata,
    output logic             mch_rvalid,
    input  wire logic [31:0] cp_fault_ev,
    input  wire logic [31:0] cp_retry_ev,
    input  wire logic [6:0]  cp_map_ev,
    input  wire logic        cm_wr_req,
    input  wire logic [2:0]  cm_wr_port,
    input  wire logic [23:0] cm_wr_addr,
    input  wire logic [63:0] cm_wr_wdata,
    input  wire logic        legacy_mode,
    output logic             cm_wr_go,
    output logic             cm_wr_reject,
    output logic      [63:0] cm_wr_data,
    input  wire logic        xl_req,
    input  wire logic [15:0] xl_page,
    input  wire logic        xl_fill,
    input  wire logic [15:0] xl_fill_frame,
    output logic             xl_hit,
    output logic             xl_fetch,
    output logic      [15:0] xl_frame,
    input  wire logic        pp_op_valid,
    input  wire logic [5:0]  pp_opcode,
    input  wire logic [11:0] pp_pc,
    output logic             pp_nop
);
    // ==========================================
    // state
    typedef struct packed {
        logic [63:0]       pfs_a;
        logic [63:0]       pfs_b;
        logic [63:0]       retry;
        logic [63:0]       maplog;
        logic [63:0]       env;
        logic [63:0]       bounds;
        logic [11:0]       pcnt;
        logic [3:0][15:0]  tag;
        logic [3:0][15:0]  frm;
        logic [3:0]        vld;
        logic [1:0]        fptr;
        logic [63:0]       rdata;
        logic              rvalid;
        logic              go;
        logic              rej;
        logic [63:0]       cmdata;
        logic              hit;
        logic              fetch;
        logic [15:0]       frame;
        logic              nop;
    } mcl_state_t;

    mcl_state_t s_q;
    mcl_state_t s_d;
    logic [3:0] hit_vec;
    logic [3:0] map_en;

    // ==========================================
    // per-unit lookup compare
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_unit
            assign map_en[gi]  = s_q.env[mcl_pkg::MCL_ENV_MAP_LO + gi];
            assign hit_vec[gi] = map_en[gi] && s_q.vld[gi]
                                 && (s_q.tag[gi] == xl_page);
        end
    endgenerate

    // ==========================================
    // next state
    always_comb begin
        logic        on_chan;
        logic        wr;
        logic        rd;
        logic        mapped;
        logic        multi;
        logic        sel;
        logic [23:0] lo;
        logic [23:0] up;
        logic [63:0] fev;
        logic [63:0] rev;
        logic [63:0] mev;
        on_chan = (mch_chan == mcl_pkg::MCL_CHAN_NUM);
        wr      = on_chan && mch_wr;
        rd      = on_chan && mch_rd;
        multi   = xl_req && ($countones(hit_vec) > 1);
        sel     = s_q.bounds[mcl_pkg::MCL_BND_PORT_LO + 32'(cm_wr_port)];
        lo      = s_q.bounds[mcl_pkg::MCL_BND_LOW_LO +: 24];
        up      = s_q.bounds[mcl_pkg::MCL_BND_UP_LO +: 24];
        mapped  = mch_addr inside {mcl_pkg::MCL_OFS_ENV, mcl_pkg::MCL_OFS_PFS_A,
                  mcl_pkg::MCL_OFS_PFS_B, mcl_pkg::MCL_OFS_RETRY,
                  mcl_pkg::MCL_OFS_MAPLOG, mcl_pkg::MCL_OFS_BOUNDS,
                  mcl_pkg::MCL_OFS_PCNT};
        s_d     = s_q;
        // cpu error sources feed these logs, plus multiple hit and link access errors into fault status
        fev     = {cp_fault_ev, 32'h0000_0000};
        rev     = {cp_retry_ev, 32'h0000_0000};
        fev[mcl_pkg::MCL_BIT_MULTI]  = fev[mcl_pkg::MCL_BIT_MULTI] | multi;
        fev[mcl_pkg::MCL_BIT_ACCESS] = fev[mcl_pkg::MCL_BIT_ACCESS]
                                       | (wr && !mapped);
        fev = fev & mcl_pkg::MCL_PFS_MASK;
        rev = rev & mcl_pkg::MCL_PFS_MASK;
        mev = {1'b0, cp_map_ev, 56'h00_0000_0000_0000};
        // sticky logs: write-one clears; in pfs_a, retry and maplog a new event wins over clear
        if (wr && mch_addr == mcl_pkg::MCL_OFS_PFS_A) begin
            s_d.pfs_a = s_q.pfs_a & ~mch_wdata;
        end
        if (wr && mch_addr == mcl_pkg::MCL_OFS_PFS_B) begin
            s_d.pfs_b = s_q.pfs_b & ~mch_wdata;
        end
        if (wr && mch_addr == mcl_pkg::MCL_OFS_RETRY) begin
            s_d.retry = s_q.retry & ~mch_wdata;
        end
        if (wr && mch_addr == mcl_pkg::MCL_OFS_MAPLOG) begin
            s_d.maplog = s_q.maplog & ~mch_wdata;
        end
        // second status copy captures the first fault seen while clear
        if (s_d.pfs_b == 64'h0000_0000_0000_0000) begin
            s_d.pfs_b = fev;
        end
        s_d.pfs_a  = s_d.pfs_a | fev;
        s_d.retry  = s_d.retry | rev;
        s_d.maplog = s_d.maplog | mev;
        // writable setup registers
        if (wr && mch_addr == mcl_pkg::MCL_OFS_ENV) begin
            s_d.env = mch_wdata;
        end
        if (wr && mch_addr == mcl_pkg::MCL_OFS_BOUNDS) begin
            s_d.bounds = mch_wdata;
        end
        // read port, unmapped reads give zero
        s_d.rvalid = rd;
        s_d.rdata  = 64'h0000_0000_0000_0000;
        if (rd) begin
            unique case (mch_addr)
                mcl_pkg::MCL_OFS_ENV:    s_d.rdata = s_q.env;
                mcl_pkg::MCL_OFS_PFS_A:  s_d.rdata = s_q.pfs_a;
                mcl_pkg::MCL_OFS_PFS_B:  s_d.rdata = s_q.pfs_b;
                mcl_pkg::MCL_OFS_RETRY:  s_d.rdata = s_q.retry;
                mcl_pkg::MCL_OFS_MAPLOG: s_d.rdata = s_q.maplog;
                mcl_pkg::MCL_OFS_BOUNDS: s_d.rdata = s_q.bounds;
                mcl_pkg::MCL_OFS_PCNT:   s_d.rdata = {52'h0_0000_0000_0000,
                                                      s_q.pcnt};
                default:                 s_d.rdata = 64'h0000_0000_0000_0000;
            endcase
        end
        // memory write bounds check
        s_d.go  = 1'b0;
        s_d.rej = 1'b0;
        if (cm_wr_req) begin
            if (sel && (cm_wr_addr < lo || cm_wr_addr > up)) begin
                s_d.rej = 1'b1;
            end else begin
                s_d.go     = 1'b1;
                s_d.cmdata = legacy_mode
                             ? (cm_wr_wdata & mcl_pkg::MCL_LEGACY_MSK)
                             : cm_wr_wdata;
            end
        end
        // translation lookup and fill
        s_d.hit   = 1'b0;
        s_d.fetch = 1'b0;
        if (xl_req) begin
            if (hit_vec != 4'h0 && !multi) begin
                s_d.hit = 1'b1;
                for (int i = 0; i < 4; i++) begin
                    if (hit_vec[i]) begin
                        s_d.frame = s_q.frm[i];
                    end
                end
            end else begin
                s_d.fetch = 1'b1;
            end
        end
        if (xl_fill) begin
            if (map_en[s_q.fptr]) begin
                s_d.tag[s_q.fptr] = xl_page;
                s_d.frm[s_q.fptr] = xl_fill_frame;
                s_d.vld[s_q.fptr] = 1'b1;
            end
            s_d.fptr = s_q.fptr + 2'd1;
        end
        // peripheral processor opcode 27 and program counter copy
        s_d.nop = pp_op_valid && (pp_opcode == mcl_pkg::MCL_OP_PCREAD);
        if (pp_op_valid) begin
            s_d.pcnt = pp_pc;
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q        <= '0;
            s_q.env    <= mcl_pkg::MCL_RST_ENV;
            s_q.bounds <= mcl_pkg::MCL_RST_BOUNDS;
            s_q.pfs_a  <= mcl_pkg::MCL_RST_LOG;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign mch_rdata    = s_q.rdata;
    assign mch_rvalid   = s_q.rvalid;
    assign cm_wr_go     = s_q.go;
    assign cm_wr_reject = s_q.rej;
    assign cm_wr_data   = s_q.cmdata;
    assign xl_hit       = s_q.hit;
    assign xl_fetch     = s_q.fetch;
    assign xl_frame     = s_q.frame;
    assign pp_nop       = s_q.nop;

    // ==========================================
    // assertions
    property p_dec_bit;
        @(posedge ref_clk) disable iff (sys_rst)
        ce && cp_fault_ev[mcl_pkg::MCL_BIT_DEC - 32] |=> s_q.pfs_a[53];
    endproperty
    a_dec_bit: assert property (p_dec_bit)
        else $error("decimal unit error not logged");

    property p_multi;
        @(posedge ref_clk) disable iff (sys_rst)
        ce && xl_req && $countones(hit_vec) > 1
        |=> s_q.pfs_a[60] && !xl_hit && xl_fetch;
    endproperty
    a_multi: assert property (p_multi)
        else $error("multiple hit not flagged");

    property p_unused;
        @(posedge ref_clk) disable iff (sys_rst)
        !s_q.pfs_a[61] && !s_q.retry[61] && !s_q.maplog[63];
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused bit set");

    property p_chan;
        @(posedge ref_clk) disable iff (sys_rst)
        ce && mch_rd && mch_chan != 5'h0f |=> !mch_rvalid;
    endproperty
    a_chan: assert property (p_chan)
        else $error("answer on wrong channel");

    property p_reject;
        @(posedge ref_clk) disable iff (sys_rst)
        ce && cm_wr_req && s_q.bounds[56 + cm_wr_port]
        && cm_wr_addr > s_q.bounds[55:32]
        |=> cm_wr_reject && !cm_wr_go;
    endproperty
    a_reject: assert property (p_reject)
        else $error("out of bounds write passed");

    property p_legacy;
        @(posedge ref_clk) disable iff (sys_rst)
        ce && cm_wr_req && legacy_mode |=> !cm_wr_go || cm_wr_data[63:60] == 4'h0;
    endproperty
    a_legacy: assert property (p_legacy)
        else $error("legacy word high bits set");

    property p_nop;
        @(posedge ref_clk) disable iff (sys_rst)
        ce && pp_op_valid && pp_opcode == 6'h17 |=> pp_nop;
    endproperty
    a_nop: assert property (p_nop)
        else $error("opcode 27 not a pass");

    property p_sticky;
        @(posedge ref_clk) disable iff (sys_rst)
        ce && s_q.retry[63] && !(mch_wr && mch_addr == 8'h90)
        |=> s_q.retry[63];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("log bit dropped without clear");

    property p_disabled;
        @(posedge ref_clk) disable iff (sys_rst)
        ce && xl_req && map_en == 4'h0 |=> xl_fetch && !xl_hit;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled unit hit");

    c_hit: cover property (@(posedge ref_clk) disable iff (sys_rst) xl_hit);
    c_rej: cover property (@(posedge ref_clk) disable iff (sys_rst)
                           cm_wr_reject);
    c_rd: cover property (@(posedge ref_clk) disable iff (sys_rst)
                          mch_rvalid && mch_rdata != 64'h0);
endmodule

/* File: design/mcl_pkg.sv */
package mcl_pkg;
    // ==========================================
    // register offsets on the service register link
    localparam logic [7:0] MCL_OFS_ENV    = 8'h30;
    localparam logic [7:0] MCL_OFS_PFS_A  = 8'h80;
    localparam logic [7:0] MCL_OFS_PFS_B  = 8'h81;
    localparam logic [7:0] MCL_OFS_RETRY  = 8'h90;
    localparam logic [7:0] MCL_OFS_MAPLOG = 8'h93;
    localparam logic [7:0] MCL_OFS_BOUNDS = 8'hc0;
    localparam logic [7:0] MCL_OFS_PCNT   = 8'hc8;
    // ==========================================
    // link channel number, 17 octal
    localparam logic [4:0] MCL_CHAN_NUM   = 5'h0f;
    // peripheral processor opcode 27 octal
    localparam logic [5:0] MCL_OP_PCREAD  = 6'h17;
    // ==========================================
    // bit positions
    localparam int MCL_LOG_LO      = 32;
    localparam int MCL_BIT_DEC     = 53;
    localparam int MCL_BIT_IMM     = 54;
    localparam int MCL_BIT_OPBUS   = 55;
    localparam int MCL_BIT_MAP_PAR = 56;
    localparam int MCL_BIT_MULTI   = 60;
    localparam int MCL_BIT_UNUSED  = 61;
    localparam int MCL_BIT_ACCESS  = 62;
    localparam int MCL_BIT_CSTORE  = 63;
    localparam int MCL_MAPLOG_LO   = 56;
    localparam int MCL_MAPLOG_TOP  = 63;
    localparam int MCL_ENV_MAP_LO  = 27;
    localparam int MCL_BND_LOW_LO  = 0;
    localparam int MCL_BND_UP_LO   = 32;
    localparam int MCL_BND_PORT_LO = 56;
    // ==========================================
    // values after reset and masks
    localparam logic [63:0] MCL_RST_LOG    = 64'h0000_0000_0000_0000;
    localparam logic [63:0] MCL_RST_ENV    = 64'h0000_0000_7800_0000;
    localparam logic [63:0] MCL_RST_BOUNDS = 64'h0000_0000_0000_0000;
    localparam logic [63:0] MCL_PFS_MASK   = 64'hdfff_ffff_0000_0000;
    localparam logic [63:0] MCL_MAP_MASK   = 64'h7f00_0000_0000_0000;
    localparam logic [63:0] MCL_LEGACY_MSK = 64'h0fff_ffff_ffff_ffff;
endpackage

/* File: dv/mcl_pp_model.sv */
module mcl_pp_model (
    input  wire logic        ref_clk,
    output logic      [4:0]  mch_chan,
    output logic             mch_rd,
    output logic             mch_wr,
    output logic      [7:0]  mch_addr,
    output logic      [63:0] mch_wdata,
    input  wire logic [63:0] mch_rdata,
    input  wire logic        mch_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // software reservation of the link
    logic chan_flag;
    initial begin
        chan_flag = 1'h0;
        mch_chan  = 5'h0f;
        mch_rd    = 1'h0;
        mch_wr    = 1'h0;
        mch_addr  = 8'h00;
        mch_wdata = 64'h0000_0000_0000_0000;
    end
    // set flag before any link traffic, without testing it first
    task automatic reserve();
        chan_flag = 1'h1;
    endtask
    // clear flag once the traffic is done
    task automatic release_flag();
        chan_flag = 1'h0;
    endtask
    // ==========================================
    // one word on the link, answer looked for over four cycles
    task automatic access(input logic [4:0] chan, input logic wr,
                          input logic [7:0] addr, input logic [63:0] wdata,
                          output logic got, output logic [63:0] data);
        int n;
        got  = 1'h0;
        data = 64'h0000_0000_0000_0000;
        @(negedge ref_clk);
        mch_chan  = chan;
        mch_rd    = !wr;
        mch_wr    = wr;
        mch_addr  = addr;
        mch_wdata = wdata;
        @(negedge ref_clk);
        mch_rd    = 1'h0;
        mch_wr    = 1'h0;
        mch_addr  = ~addr;  // released lines show the inverse
        mch_wdata = ~wdata;
        for (n = 0; n < 4 && !got; n++) begin
            if (mch_rvalid === 1'h1) begin
                got  = 1'h1;
                data = mch_rdata;
            end else begin
                @(negedge ref_clk);
            end
        end
    endtask
endmodule

/* File: dv/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, sys_rst, rvalid, g, legacy_mode, ce;
    logic [4:0]  chan;
    logic        rd, wr, cm_wr_req, cm_wr_go, cm_wr_reject;
    logic [7:0]  addr;
    logic [63:0] wdata, rdata, d, cm_wr_wdata, cm_wr_data;
    logic [31:0] f_ev, r_ev;
    logic [6:0]  m_ev;
    logic [2:0]  cm_wr_port;
    logic [23:0] cm_wr_addr;
    logic        xl_req, xl_fill, xl_hit, xl_fetch, pp_op_valid, pp_nop;
    logic [15:0] xl_page, xl_fill_frame, xl_frame;
    logic [5:0]  pp_opcode;
    logic [11:0] pp_pc;
    int          bad_count, total_checks, cyc;
    mcl_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
        .mch_chan(chan), .mch_rd(rd), .mch_wr(wr), .mch_addr(addr),
        .mch_wdata(wdata), .mch_rdata(rdata), .mch_rvalid(rvalid),
        .cp_fault_ev(f_ev), .cp_retry_ev(r_ev), .cp_map_ev(m_ev),
        .cm_wr_req(cm_wr_req), .cm_wr_port(cm_wr_port),
        .cm_wr_addr(cm_wr_addr), .cm_wr_wdata(cm_wr_wdata),
        .legacy_mode(legacy_mode), .cm_wr_go(cm_wr_go),
        .cm_wr_reject(cm_wr_reject), .cm_wr_data(cm_wr_data),
        .xl_req(xl_req), .xl_page(xl_page), .xl_fill(xl_fill),
        .xl_fill_frame(xl_fill_frame), .xl_hit(xl_hit),
        .xl_fetch(xl_fetch), .xl_frame(xl_frame),
        .pp_op_valid(pp_op_valid), .pp_opcode(pp_opcode), .pp_pc(pp_pc),
        .pp_nop(pp_nop));
    mcl_pp_model pp (.ref_clk(ref_clk), .mch_chan(chan), .mch_rd(rd),
        .mch_wr(wr), .mch_addr(addr), .mch_wdata(wdata),
        .mch_rdata(rdata), .mch_rvalid(rvalid));
    // ==========================================
    // clock and hang guard
    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            print_verdict();
        end
    end
    // ==========================================
    // compares and verdict
    task automatic chk_word(string nm, logic [63:0] e, logic [63:0] s);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk_bit(string nm, logic e, logic s);
        chk_word(nm, {63'h0, e}, {63'h0, s});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================
    // link, event, memory, lookup and opcode stimulus
    task automatic rdc(logic [7:0] a, logic [63:0] e, string nm);
        pp.access(5'h0f, 1'h0, a, 64'h0, g, d);
        chk_bit({nm, " valid"}, 1'h1, g);
        chk_word(nm, e, d);
    endtask
    task automatic wrc(logic [7:0] a, logic [63:0] v);
        pp.access(5'h0f, 1'h1, a, v, g, d);
    endtask
    task automatic ev(logic [31:0] f, logic [31:0] r, logic [6:0] m);
        @(negedge ref_clk);
        {f_ev, r_ev, m_ev} = {f, r, m};
        @(negedge ref_clk);
        {f_ev, r_ev, m_ev} = {f, r, m} ^ {f, r, m};
    endtask
    task automatic mem(logic [2:0] p, logic [23:0] a, logic ok);
        @(negedge ref_clk);
        {cm_wr_req, cm_wr_port, cm_wr_addr} = {1'h1, p, a};
        cm_wr_wdata = 64'hffff_ffff_ffff_ffff;
        @(negedge ref_clk);
        cm_wr_req = 1'h0;
        chk_bit("cm_wr_go", ok, cm_wr_go);
        chk_bit("cm_wr_reject", !ok, cm_wr_reject);
    endtask
    task automatic xl(logic fl, logic [15:0] pg, logic [15:0] fr, logic h);
        @(negedge ref_clk);
        {xl_fill, xl_req, xl_page, xl_fill_frame} = {fl, !fl, pg, fr};
        @(negedge ref_clk);
        {xl_fill, xl_req} = 2'h0;
        if (!fl) chk_bit("xl_hit", h, xl_hit);
        if (!fl) chk_bit("xl_fetch", !h, xl_fetch);
        if (!fl && h) chk_word("xl_frame", {48'h0, fr}, {48'h0, xl_frame});
    endtask
    task automatic op(logic [5:0] oc, logic [11:0] pc, logic nop);
        @(negedge ref_clk);
        {pp_op_valid, pp_opcode, pp_pc} = {1'h1, oc, pc};
        @(negedge ref_clk);
        pp_op_valid = 1'h0;
        chk_bit("pp_nop", nop, pp_nop);
    endtask
    // ==========================================
    // main sequence
    initial begin
        {sys_rst, f_ev, r_ev, m_ev, legacy_mode} = {1'h1, 71'h0, 1'h0};
        {cm_wr_req, cm_wr_port, cm_wr_addr, cm_wr_wdata} = 92'h0;
        {xl_req, xl_fill, xl_page, xl_fill_frame} = 34'h0;
        {pp_op_valid, pp_opcode, pp_pc} = 19'h0;
        {bad_count, total_checks, cyc} = {32'h0, 32'h0, 32'h0};
        ce = 1'h1;
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'h0;
        pp.reserve();
        rdc(mcl_pkg::MCL_OFS_PFS_A, mcl_pkg::MCL_RST_LOG, "pfs_a");
        rdc(mcl_pkg::MCL_OFS_ENV, mcl_pkg::MCL_RST_ENV, "env");
        for (int b = 53; b < 56; b++) begin
            ev(32'h1 << (b - 32), 32'h1 << (b - 32), 7'h0);
            rdc(mcl_pkg::MCL_OFS_PFS_A, 64'h1 << b, "pfs_a bit");
            rdc(mcl_pkg::MCL_OFS_RETRY, 64'h1 << b, "retry bit");
            wrc(mcl_pkg::MCL_OFS_PFS_A, 64'h1 << b);
            rdc(mcl_pkg::MCL_OFS_PFS_A, 64'h0, "pfs_a clr");
            wrc(mcl_pkg::MCL_OFS_RETRY, 64'h1 << b);
        end
        rdc(mcl_pkg::MCL_OFS_PFS_B, 64'h1 << 53, "pfs_b snap");
        ev(32'hffff_ffff, 32'hffff_ffff, 7'h7f);
        rdc(mcl_pkg::MCL_OFS_PFS_A, mcl_pkg::MCL_PFS_MASK, "pfs_a");
        rdc(mcl_pkg::MCL_OFS_RETRY, mcl_pkg::MCL_PFS_MASK, "retry");
        rdc(mcl_pkg::MCL_OFS_MAPLOG, mcl_pkg::MCL_MAP_MASK, "maplog");
        wrc(mcl_pkg::MCL_OFS_PFS_A, 64'hffff_ffff_ffff_ffff);
        wrc(8'h55, 64'h0000_0000_0000_0001);
        rdc(mcl_pkg::MCL_OFS_PFS_A, 64'h1 << 62, "access err");
        rdc(8'h55, 64'h0, "unmapped");
        pp.access(5'h0e, 1'h1, mcl_pkg::MCL_OFS_PFS_A, 64'h1 << 62, g, d);
        pp.access(5'h0e, 1'h0, mcl_pkg::MCL_OFS_PFS_A, 64'h0, g, d);
        chk_bit("other chan", 1'h0, g);
        rdc(mcl_pkg::MCL_OFS_PFS_A, 64'h1 << 62, "kept");
        // clock enable low: an event pulse must leave no trace
        ce = 1'h0;
        ev(32'h0040_0000, 32'h0, 7'h0);
        @(negedge ref_clk);
        ce = 1'h1;
        rdc(mcl_pkg::MCL_OFS_PFS_A, 64'h1 << 62, "frozen");
        wrc(mcl_pkg::MCL_OFS_BOUNDS, 64'h0400_01ff_0000_0100);
        rdc(mcl_pkg::MCL_OFS_BOUNDS, 64'h0400_01ff_0000_0100, "bnd");
        mem(3'h2, 24'h00_00ff, 1'h0);
        mem(3'h2, 24'h00_0100, 1'h1);
        mem(3'h2, 24'h00_01ff, 1'h1);
        mem(3'h2, 24'h00_0200, 1'h0);
        legacy_mode = 1'h1;
        mem(3'h3, 24'h00_0200, 1'h1);
        chk_word("cm_wr_data", mcl_pkg::MCL_LEGACY_MSK, cm_wr_data);
        for (int u = 0; u < 4; u++) xl(1'h1, 16'(5 + u), 16'(9 + u), 1'h0);
        xl(1'h0, 16'h0005, 16'h0009, 1'h1);
        xl(1'h0, 16'h0020, 16'h0000, 1'h0);
        wrc(mcl_pkg::MCL_OFS_ENV, 64'h0000_0000_6800_0000);
        xl(1'h0, 16'h0006, 16'h000a, 1'h0);
        xl(1'h0, 16'h0007, 16'h000b, 1'h1);
        op(mcl_pkg::MCL_OP_PCREAD, 12'habc, 1'h1);
        op(6'h16, 12'h123, 1'h0);
        rdc(mcl_pkg::MCL_OFS_PCNT, 64'h0000_0000_0000_0123, "pcnt");
        pp.release_flag();
        print_verdict();
    end
endmodule
